// [inc/lief_link_if.sv]
`default_nettype none
interface lief_link_if;
	logic                      input_ddr_clock;
	logic [lief_pkg::WORD_W-1:0] pair_one_bus;
	logic [lief_pkg::WORD_W-1:0] pair_two_bus;
	logic                      input_strobe_pin;
	logic                      output_strobe_pin;

	modport dev_mp (
		input input_ddr_clock, pair_one_bus, pair_two_bus, input_strobe_pin,
		output_strobe_pin
	);
	modport src_mp (
		output input_ddr_clock, pair_one_bus, pair_two_bus, input_strobe_pin,
		output_strobe_pin
	);
endinterface : lief_link_if
`default_nettype wire

// [inc/lief_pkg.sv]
`default_nettype none
package lief_pkg;
	localparam int WORD_W   = 16;
	localparam int SAMPLE_W = 64;
	localparam int DEPTH    = 8;
	localparam int PTR_W    = 3;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 16;
	localparam int SEL_W    = 4;
	localparam int INTERP_DEFAULT = 8;
	localparam int HALF_DEFAULT   = 4;

	typedef logic [PTR_W-1:0] lief_ptr_t;
	typedef logic [SEL_W-1:0] lief_sel_t;
	typedef enum logic [0:0] {
		SRC_LOW  = 1'b0,
		SRC_HIGH = 1'b1
	} lief_phase_t;

	// =====================================================
	// register map
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_SIF_SYNC = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_VERSION  = 8'h7F;

	localparam int CTRL_ENA_BIT   = 0;
	localparam int CTRL_START_LSB = 1;
	localparam int CTRL_SELIN_LSB = 4;
	localparam int CTRL_SELOUT_LSB = 8;
	localparam int STAT_COLL_BIT  = 0;
	localparam int STAT_WPTR_LSB  = 4;
	localparam int STAT_RPTR_LSB  = 8;
	localparam int VER_PART_LSB   = 3;
	localparam int VER_REV_LSB    = 0;

	localparam logic      ENA_RESET   = 1'h1;
	localparam lief_ptr_t START_RESET = 3'h4;
	localparam lief_ptr_t WPTR_HOME   = 3'h0;
	localparam lief_sel_t SEL_RESET   = 4'h0;

	// select field bit positions
	localparam int SEL_SYNC_BIT = 0;
	localparam int SEL_INPUT_STROBE_PIN_BIT = 1;
	localparam int SEL_OUTPUT_STROBE_PIN_BIT = 2;
	localparam int SEL_SIF_BIT  = 3;

	function automatic logic lief_sync_hit(input lief_sel_t sel, input logic input_strobe_pin_e,
		input logic output_strobe_pin_e, input logic sif_e);
		lief_sync_hit = (sel[SEL_INPUT_STROBE_PIN_BIT] & input_strobe_pin_e) | (sel[SEL_OUTPUT_STROBE_PIN_BIT] & output_strobe_pin_e)
			| (sel[SEL_SIF_BIT] & sif_e);
	endfunction : lief_sync_hit
endpackage : lief_pkg
`default_nettype wire

// [rtl/lief_ddr_capture.sv]
`default_nettype none
module lief_ddr_capture
	import lief_pkg::*;
(
	input  wire logic              clk,        // system clock
	input  wire logic              reset,      // sync reset
	input  wire logic              ddr_clk,    // data clock pin
	input  wire logic [WORD_W-1:0] bus_one,    // first pair pins
	input  wire logic [WORD_W-1:0] bus_two,    // second pair pins
	input  wire logic              strobe,     // input strobe pin
	output logic                   rise_evt,   // data clock rose
	output logic                   fall_evt,   // data clock fell
	output logic      [WORD_W-1:0] word_one,   // synced first bus
	output logic      [WORD_W-1:0] word_two,   // synced second bus
	output logic                   strobe_lvl  // synced strobe
);
	import lief_pkg::*;
	localparam int VW = 2 * WORD_W + 2;

	// =====================================================
	// pin synchroniser, one shared delay keeps data aligned to clock
	logic [VW-1:0] meta_q;
	logic [VW-1:0] sync_q;
	logic          prev_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= 1'h0;
		end else begin
			meta_q <= {ddr_clk, strobe, bus_two, bus_one};
			sync_q <= meta_q;
			prev_q <= sync_q[VW-1];
		end
	end

	assign rise_evt   = sync_q[VW-1] & ~prev_q;
	assign fall_evt   = ~sync_q[VW-1] & prev_q;
	assign strobe_lvl = sync_q[VW-2];
	assign word_one   = sync_q[WORD_W-1:0];
	assign word_two   = sync_q[2*WORD_W-1:WORD_W];
endmodule : lief_ddr_capture
`default_nettype wire

// [rtl/lief_device.sv]
`default_nettype none
module lief_device
	import lief_pkg::*;
#(
	parameter int INTERP = INTERP_DEFAULT,   // converter clock per read
	parameter logic [1:0] PART_ID  = 2'h2,   // arbitrary value
	parameter logic [2:0] REVISION = 3'h5    // arbitrary value
) (
	input  wire logic                clk,       // converter clock
	input  wire logic                reset,     // sync reset
	lief_link_if.dev_mp              link,      // pins from source
	input  wire logic   [ADDR_W-1:0] reg_addr,  // register address
	input  wire logic   [DATA_W-1:0] reg_wdata, // write data
	input  wire logic                reg_write, // write strobe
	input  wire logic                reg_read,  // read strobe
	output logic        [DATA_W-1:0] reg_rdata, // read data, next cycle
	output logic      [SAMPLE_W-1:0] out_sample, // sample to converter
	output logic                     out_valid   // one cycle per read
);
	import lief_pkg::*;

	// =====================================================
	// registers
	logic        ena_q;
	lief_ptr_t   start_q;
	lief_sel_t   sel_in_q;
	lief_sel_t   sel_out_q;
	logic        coll_q;
	logic [DATA_W-1:0] rdata_q;
	logic        sif_evt;
	logic        coll_set;
	lief_ptr_t   wr_ptr_q;
	lief_ptr_t   rd_ptr_q;

	assign sif_evt = reg_write & (reg_addr == ADDR_SIF_SYNC);

	always_ff @(posedge clk) begin
		if (reset) begin
			ena_q     <= ENA_RESET;
			start_q   <= START_RESET;
			sel_in_q  <= SEL_RESET;
			sel_out_q <= SEL_RESET;
		end else if (reg_write && reg_addr == ADDR_CTRL) begin
			ena_q     <= reg_wdata[CTRL_ENA_BIT];
			start_q   <= reg_wdata[CTRL_START_LSB +: PTR_W];
			sel_in_q  <= reg_wdata[CTRL_SELIN_LSB +: SEL_W];
			sel_out_q <= reg_wdata[CTRL_SELOUT_LSB +: SEL_W];
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			coll_q <= 1'h0;
		end else if (coll_set) begin
			coll_q <= 1'h1;
		end else if (reg_write && reg_addr == ADDR_STATUS && reg_wdata[STAT_COLL_BIT]) begin
			coll_q <= 1'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (reg_read) begin
			case (reg_addr)
				ADDR_CTRL: begin
					rdata_q <= DATA_W'({sel_out_q, sel_in_q, start_q, ena_q});
				end
				ADDR_STATUS: begin
					rdata_q <= '0;
					rdata_q[STAT_COLL_BIT] <= coll_q;
					rdata_q[STAT_WPTR_LSB +: PTR_W] <= wr_ptr_q;
					rdata_q[STAT_RPTR_LSB +: PTR_W] <= rd_ptr_q;
				end
				ADDR_VERSION: begin
					rdata_q <= '0;
					rdata_q[VER_PART_LSB +: 2] <= PART_ID;
					rdata_q[VER_REV_LSB +: 3]  <= REVISION;
				end
				default: begin
					rdata_q <= '0;
				end
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;

	// =====================================================
	// input capture
	logic              rise_evt;
	logic              fall_evt;
	logic [WORD_W-1:0] word_one;
	logic [WORD_W-1:0] word_two;
	logic              strobe_lvl;

	lief_ddr_capture u_cap (
		.clk        (clk),
		.reset      (reset),
		.ddr_clk    (link.input_ddr_clock),
		.bus_one    (link.pair_one_bus),
		.bus_two    (link.pair_two_bus),
		.strobe     (link.input_strobe_pin),
		.rise_evt   (rise_evt),
		.fall_evt   (fall_evt),
		.word_one   (word_one),
		.word_two   (word_two),
		.strobe_lvl (strobe_lvl)
	);

	logic [WORD_W-1:0]   first_one_q;
	logic [WORD_W-1:0]   first_two_q;
	logic [SAMPLE_W-1:0] sample;
	logic [SAMPLE_W-1:0] latest_q;
	logic                input_strobe_pin_q;
	logic                input_strobe_pin_edge;

	always_ff @(posedge clk) begin
		if (reset) begin
			first_one_q <= '0;
			first_two_q <= '0;
		end else if (rise_evt) begin
			first_one_q <= word_one;
			first_two_q <= word_two;
		end
	end

	// sample layout: fourth, third, second, first channel from top down
	assign sample = {word_two, first_two_q, word_one, first_one_q};

	always_ff @(posedge clk) begin
		if (reset) begin
			latest_q <= '0;
		end else if (fall_evt) begin
			latest_q <= sample;
		end
	end

	// strobe is only looked at on rising data clock edges
	always_ff @(posedge clk) begin
		if (reset) begin
			input_strobe_pin_q <= 1'h0;
		end else if (rise_evt) begin
			input_strobe_pin_q <= strobe_lvl;
		end
	end

	assign input_strobe_pin_edge = rise_evt & strobe_lvl & ~input_strobe_pin_q;

	// =====================================================
	// output strobe, sampled by the converter clock
	logic output_strobe_pin_meta_q;
	logic output_strobe_pin_sync_q;
	logic output_strobe_pin_prev_q;
	logic output_strobe_pin_edge;

	always_ff @(posedge clk) begin
		if (reset) begin
			output_strobe_pin_meta_q <= 1'h0;
			output_strobe_pin_sync_q <= 1'h0;
			output_strobe_pin_prev_q <= 1'h0;
		end else begin
			output_strobe_pin_meta_q <= link.output_strobe_pin;
			output_strobe_pin_sync_q <= output_strobe_pin_meta_q;
			output_strobe_pin_prev_q <= output_strobe_pin_sync_q;
		end
	end

	assign output_strobe_pin_edge = output_strobe_pin_sync_q & ~output_strobe_pin_prev_q;

	// =====================================================
	// buffer storage and write side
	logic [SAMPLE_W-1:0] mem_q [DEPTH];
	logic                wr_sync;

	assign wr_sync = lief_sync_hit(sel_in_q, input_strobe_pin_edge, output_strobe_pin_edge, sif_evt);

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_q <= WPTR_HOME;
		end else if (wr_sync) begin
			wr_ptr_q <= WPTR_HOME;
		end else if (fall_evt) begin
			wr_ptr_q <= wr_ptr_q + 3'h1;
		end
	end

	for (genvar i = 0; i < DEPTH; i++) begin : g_loc
		always_ff @(posedge clk) begin
			if (reset) begin
				mem_q[i] <= '0;
			end else if (fall_evt && wr_ptr_q == PTR_W'(i)) begin
				mem_q[i] <= sample;
			end
		end
	end

	// =====================================================
	// read side, one read per INTERP converter clocks
	logic [7:0] div_q;
	logic       tick;
	logic       rd_input_strobe_pin_q;
	logic       rd_input_strobe_pin_edge;
	logic       output_strobe_pin_pend_q;
	logic       sif_pend_q;
	logic       rd_sync;
	lief_ptr_t  rd_addr;

	assign tick = (div_q == 8'(INTERP - 1));

	always_ff @(posedge clk) begin
		if (reset || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// phase ambiguity here is why the output strobe is preferred
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_input_strobe_pin_q <= 1'h0;
		end else if (tick) begin
			rd_input_strobe_pin_q <= input_strobe_pin_q;
		end
	end

	assign rd_input_strobe_pin_edge = input_strobe_pin_q & ~rd_input_strobe_pin_q;

	// events between ticks wait for the next read; new event beats consume
	always_ff @(posedge clk) begin
		if (reset) begin
			output_strobe_pin_pend_q <= 1'h0;
			sif_pend_q  <= 1'h0;
		end else begin
			output_strobe_pin_pend_q <= output_strobe_pin_edge | (output_strobe_pin_pend_q & ~tick);
			sif_pend_q  <= sif_evt | (sif_pend_q & ~tick);
		end
	end

	assign rd_sync = tick & lief_sync_hit(sel_out_q, rd_input_strobe_pin_edge, output_strobe_pin_pend_q,
		sif_pend_q);
	assign rd_addr = rd_sync ? start_q : rd_ptr_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_ptr_q <= START_RESET;
		end else if (tick) begin
			rd_ptr_q <= rd_addr + 3'h1;
		end
	end

	assign coll_set = tick & ena_q & (rd_addr == wr_ptr_q);

	always_ff @(posedge clk) begin
		if (reset) begin
			out_sample <= '0;
			out_valid  <= 1'h0;
		end else begin
			out_valid <= tick;
			if (tick) begin
				out_sample <= ena_q ? mem_q[rd_addr] : latest_q;
			end
		end
	end
endmodule : lief_device
`default_nettype wire

// [rtl/lief_source.sv]
`default_nettype none
module lief_source
	import lief_pkg::*;
#(
	parameter int HALF = HALF_DEFAULT   // clk cycles per data clock half
) (
	input  wire logic                clk,       // system clock
	input  wire logic                reset,     // sync reset
	lief_link_if.src_mp              link,      // pins to device
	input  wire logic [SAMPLE_W-1:0] smp_data,  // channels, first lowest
	input  wire logic                smp_valid, // sample offered
	output logic                     smp_ready, // sample taken this cycle
	input  wire logic                in_sync,   // request input strobe
	input  wire logic                out_sync   // request output strobe
);
	import lief_pkg::*;

	lief_phase_t       phase_q;
	logic [7:0]        cnt_q;
	logic [WORD_W-1:0] one_q;
	logic [WORD_W-1:0] two_q;
	logic [WORD_W-1:0] hold_one_q;
	logic [WORD_W-1:0] hold_two_q;
	logic              ddr_q;
	logic              input_strobe_pin_q;
	logic              ipend_q;
	logic              output_strobe_pin_q;
	logic              start;
	logic              last;

	assign start     = (cnt_q == 8'h00);
	assign last      = (cnt_q == 8'(HALF - 1));
	assign smp_ready = start & (phase_q == SRC_LOW);

	// =====================================================
	// data clock divider; data moves one cycle after each edge
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q   <= '0;
			phase_q <= SRC_LOW;
			ddr_q   <= 1'h0;
		end else if (last) begin
			cnt_q <= '0;
			ddr_q <= ~ddr_q;
			case (phase_q)
				SRC_LOW: phase_q <= SRC_HIGH;
				SRC_HIGH: phase_q <= SRC_LOW;
				default: phase_q <= SRC_LOW;
			endcase
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			one_q      <= '0;
			two_q      <= '0;
			hold_one_q <= '0;
			hold_two_q <= '0;
		end else if (start && phase_q == SRC_LOW) begin
			if (smp_valid) begin
				one_q      <= smp_data[0 +: WORD_W];
				two_q      <= smp_data[2*WORD_W +: WORD_W];
				hold_one_q <= smp_data[WORD_W +: WORD_W];
				hold_two_q <= smp_data[3*WORD_W +: WORD_W];
			end
		end else if (start) begin
			one_q <= hold_one_q;
			two_q <= hold_two_q;
		end
	end

	// strobe stays high a whole data clock period around one rise
	always_ff @(posedge clk) begin
		if (reset) begin
			ipend_q <= 1'h0;
			input_strobe_pin_q  <= 1'h0;
		end else begin
			if (start && phase_q == SRC_LOW) begin
				input_strobe_pin_q  <= ipend_q | in_sync;
				ipend_q <= 1'h0;
			end else if (in_sync) begin
				ipend_q <= 1'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			output_strobe_pin_q <= 1'h0;
		end else begin
			output_strobe_pin_q <= out_sync;
		end
	end

	assign link.input_ddr_clock   = ddr_q;
	assign link.pair_one_bus      = one_q;
	assign link.pair_two_bus      = two_q;
	assign link.input_strobe_pin  = input_strobe_pin_q;
	assign link.output_strobe_pin = output_strobe_pin_q;
endmodule : lief_source
`default_nettype wire

// [verif/lief_chk.sv]
`default_nettype none
module lief_chk #(
	parameter int HALF = 4   // clk cycles per data clock half
) (
	input wire logic        clk,               // system clock
	input wire logic        reset,             // sync reset
	input wire logic        input_ddr_clock,   // data clock
	input wire logic [15:0] pair_one_bus,      // first bus
	input wire logic [15:0] pair_two_bus,      // second bus
	input wire logic        input_strobe_pin,  // input strobe
	input wire logic        output_strobe_pin  // output strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// =====================================================
	// helpers
	logic [3:0] warm_q;
	logic [3:0] run_q;
	logic       ddr_q;
	// link start-up is not framed, so window checks wait a while
	always_ff @(posedge clk) begin
		if (reset) warm_q <= 4'h0;
		else if (warm_q != 4'hF) warm_q <= warm_q + 4'h1;
	end
	always_ff @(posedge clk) begin
		ddr_q <= input_ddr_clock;
		if (reset || input_ddr_clock != ddr_q) run_q <= 4'h0;
		else if (run_q != 4'hF) run_q <= run_q + 4'h1;
	end
	// =====================================================
	// assertions
	chk_ddr_high_half: assert property ($rose(input_ddr_clock) |->
		input_ddr_clock[*4] ##1 !input_ddr_clock) else $error("data clock high half wrong");
	chk_ddr_low_half: assert property ($fell(input_ddr_clock) |->
		!input_ddr_clock[*4] ##1 input_ddr_clock) else $error("data clock low half wrong");
	chk_ddr_half_bound: assert property (warm_q == 4'hF |-> run_q < HALF)
		else $error("data clock stalled");
	chk_bus_one_window: assert property (warm_q == 4'hF && $changed(pair_one_bus) |->
		$past(input_ddr_clock) != $past(input_ddr_clock, 2)) else $error("bus one off edge");
	chk_bus_two_window: assert property (warm_q == 4'hF && $changed(pair_two_bus) |->
		$past(input_ddr_clock) != $past(input_ddr_clock, 2)) else $error("bus two off edge");
	chk_input_strobe_pin_width: assert property ($rose(input_strobe_pin) |->
		input_strobe_pin[*8] ##1 !input_strobe_pin) else $error("strobe width wrong");
	chk_input_strobe_pin_spans_rise: assert property ($rose(input_strobe_pin) |->
		##[1:8] $rose(input_ddr_clock)) else $error("strobe misses rising edge");
	chk_output_strobe_pin_one_pulse: assert property ($rose(output_strobe_pin) |=>
		!output_strobe_pin) else $error("output strobe too long");
endmodule : lief_chk
`default_nettype wire

// [verif/lvds_input_elastic_fifo_tb.sv]
`default_nettype none
module lvds_input_elastic_fifo_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lief_pkg::*;
	localparam int HALF = 4;
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic              reg_write = 1'b0;
	logic              reg_read = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [SAMPLE_W-1:0] out_sample;
	logic              out_valid;
	logic [SAMPLE_W-1:0] smp_data = 64'hD400_C300_B200_A100;
	logic              smp_valid = 1'b1;
	logic              smp_ready;
	logic              in_sync = 1'b0;
	logic              out_sync = 1'b0;
	logic [7:0]        widx = 8'h00;
	int                fail_count = 0;
	int                samples_checked = 0;
	lief_link_if link ();
	lief_device lief_device_inst (.clk(clk), .reset(reset), .link(link.dev_mp),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .out_sample(out_sample),
		.out_valid(out_valid));
	lief_source #(.HALF(HALF)) lief_source_inst (.clk(clk), .reset(reset),
		.link(link.src_mp), .smp_data(smp_data), .smp_valid(smp_valid),
		.smp_ready(smp_ready), .in_sync(in_sync), .out_sync(out_sync));
	lief_chk #(.HALF(HALF)) lief_chk_inst (.clk(clk), .reset(reset),
		.input_ddr_clock(link.input_ddr_clock), .pair_one_bus(link.pair_one_bus),
		.pair_two_bus(link.pair_two_bus), .input_strobe_pin(link.input_strobe_pin),
		.output_strobe_pin(link.output_strobe_pin));
	always #2.5 clk = ~clk;
	// =====================================================
	// stimulus helpers
	// byte patterns differ per channel so lane or bit swaps show
	function automatic logic [63:0] pat(input logic [7:0] i);
		pat = {8'hD4, i, 8'hC3, i, 8'hB2, i, 8'hA1, i};
	endfunction : pat
	always @(posedge clk) begin
		if (smp_ready === 1'b1) begin
			widx <= widx + 8'h01;
			smp_data <= pat(widx + 8'h01);
		end
	end
	task automatic finish_test();
		if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_rd
	task automatic wait_valid(output int gap);
		int i;
		for (i = 1; i <= 40; i++) begin
			@(posedge clk);
			#1;
			if (out_valid === 1'b1) break;
		end
		gap = i;
		if (i > 40) begin
			fail_count++;
			$display("unexpected at %0t: no sample tick", $time);
			finish_test();
		end
	endtask : wait_valid
	// =====================================================
	// scenarios
	task automatic test_regs();
		logic [15:0] d;
		reg_rd(ADDR_VERSION, d);
		check(d, 16'h0015);
		reg_wr(ADDR_VERSION, 16'hFFFF);
		reg_rd(ADDR_VERSION, d);
		check(d, 16'h0015);
		reg_rd(8'h55, d);
		check(d, 16'h0000);
		reg_rd(ADDR_CTRL, d);
		check(d, 16'h0009);
	endtask : test_regs
	task automatic test_stream(input int n);
		int g;
		logic [7:0] prev;
		repeat (16) wait_valid(g);
		prev = out_sample[7:0];
		repeat (n) begin
			wait_valid(g);
			check(g, 8);
			check(out_sample, pat(prev + 8'h01));
			prev = out_sample[7:0];
		end
	endtask : test_stream
	// one start value in eight lines the read address on the write pointer
	task automatic sweep(input logic [7:0] sel, input int kind, output int hits);
		int g;
		logic [15:0] d;
		hits = 0;
		for (int s = 0; s < 8; s++) begin
			reg_wr(ADDR_CTRL, {4'h0, sel, s[2:0], 1'b1});
			wait_valid(g);
			if (kind == 0) begin
				reg_wr(ADDR_SIF_SYNC, 16'h0000);
			end else begin
				@(posedge clk);
				in_sync  <= (kind == 1);
				out_sync <= (kind == 2);
			end
			@(posedge clk);
			in_sync <= 1'b0;
			out_sync <= 1'b0;
			repeat (4) wait_valid(g);
			reg_wr(ADDR_STATUS, 16'h0001);
			repeat (3) wait_valid(g);
			reg_rd(ADDR_STATUS, d);
			if (d[STAT_COLL_BIT] === 1'b1) hits++;
		end
	endtask : sweep
	task automatic test_syncs();
		int h;
		sweep(8'h88, 0, h);
		check(h, 1);
		sweep(8'h00, 0, h);
		check(h == 0 || h == 8, 1'b1);
		sweep(8'h22, 1, h);
		check(h, 1);
		sweep(8'h40, 2, h);
		check(h, 1);
	endtask : test_syncs
	task automatic test_bypass();
		int g;
		logic [7:0] prev;
		logic [15:0] d;
		reg_wr(ADDR_CTRL, 16'h0888);
		reg_wr(ADDR_STATUS, 16'h0001);
		test_stream(12);
		// a pointer sync must not disturb the bypassed stream
		prev = out_sample[7:0];
		reg_wr(ADDR_SIF_SYNC, 16'h0000);
		repeat (4) begin
			wait_valid(g);
			check(out_sample, pat(prev + 8'h01));
			prev = out_sample[7:0];
		end
		reg_rd(ADDR_STATUS, d);
		check(d[STAT_COLL_BIT], 1'b0);
	endtask : test_bypass
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		test_regs();
		test_stream(12);
		test_syncs();
		test_bypass();
		finish_test();
	end
endmodule : lvds_input_elastic_fifo_tb
`default_nettype wire
